//--- inc/srap_defs.vh
`ifndef SRAP_DEFS_VH
`define SRAP_DEFS_VH

// ==========================================================
// Timing
`define SRAP_CLK_NS        10
`define SRAP_FILT_NS       50
`define SRAP_FILT_CYC      ((`SRAP_FILT_NS + `SRAP_CLK_NS - 1) / `SRAP_CLK_NS)

// ==========================================================
// Addressing and register map
`define SRAP_SLAVE_ADDR_HI 6'h2A
`define SRAP_NUM_REGS      40
`define SRAP_LAST_REG      7'h27
`define SRAP_BYTE_BITS     4'h8
`define SRAP_LAST_BIT      4'h7
`define SRAP_RW_READ       1'b1
`define SRAP_LINE_IDLE     1'b1
`define SRAP_PIN_RST       1'b0

`endif

//--- core/srap_glitch_filter.v
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.vh"

module srap_glitch_filter #(
	parameter WIDTH    = 2,
	parameter FILT_CYC = `SRAP_FILT_CYC,
	parameter CNT_W    = 4
) (
	input  wire             mclk,
	input  wire             nrst,
	input  wire             filt_en,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_out
);

	// Cut to the counter width on purpose
	localparam integer     FILT_LAST_I = FILT_CYC - 1;
	localparam [CNT_W-1:0] FILT_LAST   = FILT_LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ONE     = {{(CNT_W-1){1'b0}}, 1'b1};

	genvar g;
	// ==========================================================
	// Per-line synchroniser and stability filter
	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : g_line
			reg             meta_reg;
			reg             sync_reg;
			reg             out_reg;
			reg [CNT_W-1:0] cnt_reg;
			// New level must hold FILT_CYC cycles before it passes
			always @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
				begin
					meta_reg <= `SRAP_LINE_IDLE;
					sync_reg <= `SRAP_LINE_IDLE;
					out_reg  <= `SRAP_LINE_IDLE;
					cnt_reg  <= {CNT_W{1'b0}};
				end
				else
				begin
					meta_reg <= pin_in[g];
					sync_reg <= meta_reg;
					if (sync_reg == out_reg)
						cnt_reg <= {CNT_W{1'b0}};
					else if (!filt_en || cnt_reg == FILT_LAST)
					begin
						out_reg <= sync_reg;
						cnt_reg <= {CNT_W{1'b0}};
					end
					else
						cnt_reg <= cnt_reg + CNT_ONE;
				end
			end
			assign pin_out[g] = out_reg;
		end
	endgenerate

endmodule // srap_glitch_filter
`default_nettype wire

//--- core/srap_regfile.v
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.vh"

module srap_regfile #(
	parameter                    NUM_REGS   = `SRAP_NUM_REGS,
	parameter                    IDX_W      = 7,
	parameter [NUM_REGS*8-1:0]   RESET_VALS = {NUM_REGS{8'h00}}
) (
	input  wire                  mclk,
	input  wire                  nrst,
	input  wire                  wr_en,
	input  wire [IDX_W-1:0]      wr_idx,
	input  wire [7:0]            wr_data,
	input  wire [IDX_W-1:0]      rd_idx,
	output wire [7:0]            rd_data,
	output wire [NUM_REGS*8-1:0] regs_flat
);

	genvar g;
	// ==========================================================
	// Register storage, one byte per index
	generate
		for (g = 0; g < NUM_REGS; g = g + 1)
		begin : g_reg
			localparam integer     MY_NUM = g;
			localparam [IDX_W-1:0] MY_IDX = MY_NUM[IDX_W-1:0];
			reg [7:0] store_reg;
			// Defaults come back on every reset
			always @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					store_reg <= RESET_VALS[g*8 +: 8];
				else if (wr_en && wr_idx == MY_IDX)
					store_reg <= wr_data;
			end
			assign regs_flat[g*8 +: 8] = store_reg;
		end
	endgenerate

	// Caller keeps rd_idx inside the map
	assign rd_data = regs_flat[rd_idx*8 +: 8];

endmodule // srap_regfile
`default_nettype wire

//--- core/srap_top.v
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.vh"

module srap_top #(
	parameter                  NUM_REGS   = `SRAP_NUM_REGS,
	parameter [NUM_REGS*8-1:0] RESET_VALS = {NUM_REGS{8'h00}}
) (
	input  wire                  mclk,
	input  wire                  nrst,
	input  wire                  scl_i,
	input  wire                  sda_i,
	output wire                  sda_o,
	output wire                  sda_oe,
	input  wire                  addr_select_filter_pin,
	output wire [NUM_REGS*8-1:0] regs_flat,
	output wire                  xfer_active,
	output wire                  timing_gen_reset
);

	// ==========================================================
	// States and byte phases
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RX   = 3'h1;
	localparam [2:0] ST_ACK  = 3'h2;
	localparam [2:0] ST_TX   = 3'h3;
	localparam [2:0] ST_MACK = 3'h4;

	localparam [1:0] PH_ADDR = 2'h0;
	localparam [1:0] PH_SUB  = 2'h1;
	localparam [1:0] PH_DATA = 2'h2;

	localparam [6:0] PTR_ONE = 7'h01;
	localparam [3:0] CNT_ONE = 4'h1;

	// ==========================================================
	// Declarations
	reg        asel_meta_reg;
	reg        asel_sync_reg;
	reg        scl_prev_reg;
	reg        sda_prev_reg;
	reg        tg_rst_reg;

	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [1:0] phase_reg;
	reg  [1:0] phase_next;
	reg  [3:0] bit_cnt_reg;
	reg  [3:0] bit_cnt_next;
	reg  [7:0] shift_reg;
	reg  [7:0] shift_next;
	reg  [6:0] ptr_reg;
	reg  [6:0] ptr_next;
	reg        rw_reg;
	reg        rw_next;
	reg        oe_reg;
	reg        oe_next;
	reg        nack_reg;
	reg        nack_next;
	reg        wr_en;

	wire [1:0] line_flt;
	wire       scl_f;
	wire       sda_f;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;
	wire [6:0] own_addr;
	wire [6:0] rd_idx;
	wire [7:0] rd_data;

	// ==========================================================
	// Subaddress check shared by subaddress and data phases
	function reg_exists;
		input [7:0] sub;
		begin
			reg_exists = (sub[7] == 1'b0) && (sub[6:0] <= `SRAP_LAST_REG);
		end
	endfunction

	// ==========================================================
	// Pin conditioning
	// Select pin is a static strap but still passes two flops
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			asel_meta_reg <= `SRAP_PIN_RST;
			asel_sync_reg <= `SRAP_PIN_RST;
		end
		else
		begin
			asel_meta_reg <= addr_select_filter_pin;
			asel_sync_reg <= asel_meta_reg;
		end
	end

	// Filter is switched on while the select pin is high and bypassed while it is low
	srap_glitch_filter #(
		.WIDTH    (2),
		.FILT_CYC (`SRAP_FILT_CYC),
		.CNT_W    (4)
	) u_filter (
		.mclk    (mclk),
		.nrst    (nrst),
		.filt_en (asel_sync_reg),
		.pin_in  ({scl_i, sda_i}),
		.pin_out (line_flt)
	);

	assign scl_f = line_flt[1];
	assign sda_f = line_flt[0];

	// Previous filtered levels for edge and condition detection
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_prev_reg <= `SRAP_LINE_IDLE;
			sda_prev_reg <= `SRAP_LINE_IDLE;
		end
		else
		begin
			scl_prev_reg <= scl_f;
			sda_prev_reg <= sda_f;
		end
	end

	// Both lines are filtered alike, so a data edge never looks like a start
	assign scl_rise  = scl_f & ~scl_prev_reg;
	assign scl_fall  = ~scl_f & scl_prev_reg;
	assign start_det = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
	assign stop_det  = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

	// Lowest address bit comes from the strap
	assign own_addr = {`SRAP_SLAVE_ADDR_HI, asel_sync_reg};

	// ==========================================================
	// Register file
	// A pointer left past the map after a write reads the top register
	assign rd_idx = (ptr_reg > `SRAP_LAST_REG) ? `SRAP_LAST_REG : ptr_reg;

	srap_regfile #(
		.NUM_REGS   (NUM_REGS),
		.IDX_W      (7),
		.RESET_VALS (RESET_VALS)
	) u_regs (
		.mclk      (mclk),
		.nrst      (nrst),
		.wr_en     (wr_en),
		.wr_idx    (ptr_reg),
		.wr_data   (shift_reg),
		.rd_idx    (rd_idx),
		.rd_data   (rd_data),
		.regs_flat (regs_flat)
	);

	// ==========================================================
	// Protocol state machine, next state
	always @*
	begin
		state_next   = state_reg;
		phase_next   = phase_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next   = shift_reg;
		ptr_next     = ptr_reg;
		rw_next      = rw_reg;
		oe_next      = oe_reg;
		nack_next    = nack_reg;
		wr_en        = 1'b0;
		if (stop_det)
		begin
			// Stop ends any transfer and frees the line
			state_next = ST_IDLE;
			oe_next    = 1'b0;
		end
		else if (start_det)
		begin
			// Start, repeated or stray, always restarts address reception
			state_next   = ST_RX;
			phase_next   = PH_ADDR;
			bit_cnt_next = 4'h0;
			oe_next      = 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					oe_next = 1'b0;
				end
				ST_RX:
				begin
					if (scl_rise && bit_cnt_reg != `SRAP_BYTE_BITS)
					begin
						// MSB arrives first
						shift_next   = {shift_reg[6:0], sda_f};
						bit_cnt_next = bit_cnt_reg + CNT_ONE;
					end
					else if (scl_fall && bit_cnt_reg == `SRAP_BYTE_BITS)
					begin
						case (phase_reg)
							PH_ADDR:
							begin
								if (shift_reg[7:1] == own_addr)
								begin
									rw_next    = shift_reg[0];
									oe_next    = 1'b1;
									state_next = ST_ACK;
									phase_next = PH_SUB;
								end
								else
									state_next = ST_IDLE;
							end
							PH_SUB:
							begin
								if (reg_exists(shift_reg))
								begin
									ptr_next   = shift_reg[6:0];
									oe_next    = 1'b1;
									state_next = ST_ACK;
									phase_next = PH_DATA;
								end
								else
									state_next = ST_IDLE;
							end
							default:
							begin
								if (reg_exists({1'b0, ptr_reg}))
								begin
									wr_en      = 1'b1;
									ptr_next   = ptr_reg + PTR_ONE;
									oe_next    = 1'b1;
									state_next = ST_ACK;
								end
								else
									state_next = ST_IDLE;
							end
						endcase
					end
				end
				ST_ACK:
				begin
					// Hold the acknowledge through the ninth pulse
					if (scl_fall)
					begin
						bit_cnt_next = 4'h0;
						if (rw_reg == `SRAP_RW_READ)
						begin
							shift_next = rd_data;
							oe_next    = ~rd_data[7];
							state_next = ST_TX;
						end
						else
						begin
							oe_next    = 1'b0;
							state_next = ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_reg == `SRAP_LAST_BIT)
						begin
							// Release for the master's answer; pointer sticks at the top
							oe_next      = 1'b0;
							bit_cnt_next = 4'h0;
							state_next   = ST_MACK;
							if (ptr_reg < `SRAP_LAST_REG)
								ptr_next = ptr_reg + PTR_ONE;
							else
								ptr_next = `SRAP_LAST_REG;
						end
						else
						begin
							shift_next   = {shift_reg[6:0], 1'b0};
							oe_next      = ~shift_reg[6];
							bit_cnt_next = bit_cnt_reg + CNT_ONE;
						end
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
						nack_next = sda_f;
					else if (scl_fall)
					begin
						if (nack_reg)
							state_next = ST_IDLE;
						else
						begin
							shift_next   = rd_data;
							oe_next      = ~rd_data[7];
							bit_cnt_next = 4'h0;
							state_next   = ST_TX;
						end
					end
				end
				default:
				begin
					state_next = ST_IDLE;
					oe_next    = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Protocol state machine, registers
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg   <= ST_IDLE;
			phase_reg   <= PH_ADDR;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			ptr_reg     <= 7'h00;
			rw_reg      <= 1'b0;
			oe_reg      <= 1'b0;
			nack_reg    <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			phase_reg   <= phase_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
			ptr_reg     <= ptr_next;
			rw_reg      <= rw_next;
			oe_reg      <= oe_next;
			nack_reg    <= nack_next;
		end
	end

	// ==========================================================
	// Timing generator reset, held through reset and cleared on the first edge after
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			tg_rst_reg <= 1'b1;
		else
			tg_rst_reg <= 1'b0;
	end

	// ==========================================================
	// Outputs
	// Only a low is ever driven, so the line stays open-drain
	assign sda_o            = 1'b0;
	assign sda_oe           = oe_reg;
	assign xfer_active      = (state_reg != ST_IDLE);
	assign timing_gen_reset = tg_rst_reg;

endmodule // srap_top
`default_nettype wire

//--- dv/srap_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker
module srap_properties #(
	parameter NUM_REGS = 40
) (
	input wire logic                  mclk,
	input wire logic                  nrst,
	input wire logic                  scl_i,
	input wire logic                  sda_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe,
	input wire logic                  addr_select_filter_pin,
	input wire logic [NUM_REGS*8-1:0] regs_flat,
	input wire logic                  xfer_active,
	input wire logic                  timing_gen_reset
);
	default clocking dclk @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// Pin holds of seven cycles outlast the filter, so glitches never arm these
	a_low_only: assert property (sda_oe |-> sda_o == 1'b0)
		else $error("sda driven high");
	a_tgen_pulse: assert property (timing_gen_reset |=> !timing_gen_reset)
		else $error("timing reset stuck");
	a_idle_quiet: assert property (!xfer_active [*2] |-> !sda_oe)
		else $error("sda pulled while idle");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_i, 2))
		else $error("sda changed outside clock low");
	a_regs_on_ack: assert property ($changed(regs_flat) |-> $rose(sda_oe))
		else $error("register written without ack");
	a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("ack too short");
	// SCL must already be high: a data edge may land beside an SCL rise
	a_start_busy: assert property ($fell(sda_i) && scl_i && $past(scl_i)
		##1 (!sda_i && scl_i) [*6] |-> ##[0:8] xfer_active)
		else $error("start not seen");
	a_stop_idle: assert property ($rose(sda_i) && scl_i && $past(scl_i)
		##1 (sda_i && scl_i) [*6] |-> ##[0:8] !xfer_active)
		else $error("stop not seen");
endmodule // srap_properties
bind srap_top srap_properties #(.NUM_REGS(NUM_REGS)) srap_properties_i (.mclk(mclk), .nrst(nrst), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_filter_pin(addr_select_filter_pin),
	.regs_flat(regs_flat), .xfer_active(xfer_active), .timing_gen_reset(timing_gen_reset));
`default_nettype wire

//--- dv/srap_bfm.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Serial bus master, 160 ns clock period
module srap_bfm (
	input  wire logic mclk,
	input  wire logic sda,
	output var logic  scl = 1'b1,
	output var logic  sda_m = 1'b1
);
	// Quarter bit time, ends just after a clock edge
	task automatic qt;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// One start per clock high, also as repeated start
	task automatic start;
		sda_m = 1'b1;
		qt();
		scl = 1'b1;
		qt();
		qt();
		sda_m = 1'b0;
		qt();
		qt();
		scl = 1'b0;
		qt();
	endtask
	task automatic stop;
		sda_m = 1'b0;
		qt();
		scl = 1'b1;
		qt();
		qt();
		sda_m = 1'b1;
		qt();
		qt();
	endtask
	// Data set mid clock low, sampled mid clock high
	task automatic bitx(input logic b, output logic r);
		sda_m = b;
		qt();
		scl = 1'b1;
		qt();
		r = sda;
		qt();
		scl = 1'b0;
		qt();
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	// Last byte of a read gets no ack
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
	// Noise spike, shorter than the filter span
	task automatic pulse;
		sda_m = 1'b0;
		#30 sda_m = 1'b1;
	endtask
endmodule // srap_bfm
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.vh"
// ==========================================
// Bench
module testbench;
	localparam NREG = 40;
	logic            mclk = 1'b0;
	logic            nrst = 1'b0;
	logic            pin = 1'b0;
	wire             scl;
	wire             sda_m;
	wire             sda_o;
	wire             sda_oe;
	wire             xfer;
	wire             tgr;
	wire [NREG*8-1:0] regs;
	logic [7:0]      mem [0:NREG-1];
	logic [7:0]      d;
	logic [7:0]      s;
	logic            a;
	int              err_count = 0;
	int              checks_done = 0;
	int              seed = 32'h5597;
	int              cyc = 0;
	// Pull-up wire, device can only pull low
	wire sda = sda_m & (sda_oe ? sda_o : 1'b1);

	always #5 mclk = ~mclk;

	srap_top #(.NUM_REGS(NREG)) srap_top_i (.mclk(mclk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_select_filter_pin(pin), .regs_flat(regs), .xfer_active(xfer), .timing_gen_reset(tgr));
	srap_bfm srap_bfm_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));

	function automatic logic [7:0] dev_addr(input logic p, input logic r);
		return {`SRAP_SLAVE_ADDR_HI, p, r};
	endfunction
	// Reads past the top repeat the last register
	function automatic logic [7:0] rd_exp(input int p);
		return mem[(p > NREG - 1) ? NREG - 1 : p];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic regs_chk;
		for (int i = 0; i < NREG; i++)
			chk(regs[i*8+:8], mem[i]);
	endtask
	// Bus must be idle shortly after the stop
	task automatic end_xfer;
		srap_bfm_i.stop();
		repeat (12) @(posedge mclk);
		#1 chk(xfer, 1'b0);
	endtask
	task automatic wr(input logic [7:0] sub, input int n);
		int p;
		p = sub;
		srap_bfm_i.start();
		srap_bfm_i.put(dev_addr(pin, 1'b0), a);
		chk(a, 1'b1);
		srap_bfm_i.put(sub, a);
		chk(a, sub < NREG);
		for (int i = 0; i < n && a; i++)
		begin
			d = 8'($random(seed));
			srap_bfm_i.put(d, a);
			chk(a, p < NREG);
			if (p < NREG)
				mem[p] = d;
			p++;
		end
		end_xfer();
	endtask
	task automatic rd(input logic [7:0] sub, input int n);
		srap_bfm_i.start();
		srap_bfm_i.put(dev_addr(pin, 1'b0), a);
		srap_bfm_i.put(sub, a);
		srap_bfm_i.start();
		srap_bfm_i.put(dev_addr(pin, 1'b1), a);
		chk(a, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			srap_bfm_i.get(i == n - 1, d);
			chk(d, rd_exp(sub + i));
		end
		end_xfer();
	endtask

	// Hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			err_count++;
			test_done();
		end
	end

	// Main sequence, once per filter setting
	initial
	begin
		logic seen;
		for (int i = 0; i < NREG; i++)
			mem[i] = 8'h00;
		repeat (20) @(posedge mclk);
		#1 nrst = 1'b1;
		repeat (6) @(posedge mclk);
		#1 chk(tgr, 1'b0);
		regs_chk();
		for (int k = 0; k < 2; k++)
		begin
			pin = k[0];
			repeat (8) @(posedge mclk);
			#1 seen = 1'b0;
			fork
				srap_bfm_i.pulse();
				repeat (16)
				begin
					@(posedge mclk);
					#1 seen |= xfer;
				end
			join
			chk(seen, !pin);
			s = 8'($random(seed) & 32'h1F);
			wr(s, 3);
			rd(s, 3);
			srap_bfm_i.start();
			srap_bfm_i.put(dev_addr(~pin, 1'b0), a);
			chk(a, 1'b0);
			srap_bfm_i.put(8'h00, a);
			chk(a, 1'b0);
			end_xfer();
			wr(8'h28, 1);
			wr(8'hA5, 1);
			wr(8'h27, 2);
			rd(8'h26, 3);
			regs_chk();
			$display("test %0d done", k);
		end
		nrst = 1'b0;
		@(posedge mclk);
		#1 chk(tgr, 1'b1);
		chk(xfer, 1'b0);
		for (int i = 0; i < NREG; i++)
			mem[i] = 8'h00;
		regs_chk();
		nrst = 1'b1;
		repeat (6) @(posedge mclk);
		#1 chk(tgr, 1'b0);
		wr(8'h00, 1);
		regs_chk();
		$display("reset test done");
		test_done();
	end
endmodule // testbench
`default_nettype wire
